// File: include/adc_seq_pkg.sv
// Purpose: Shared constants and types of the channel sequencer.
// Assumes: A twelve-bit control word and an eight-bit channel mask.
// Notes:   Field positions count from bit 0 of the bus data.
package adc_seq_pkg;
  localparam int          CTRL_W         = 12;
  localparam int          MASK_W         = 8;
  localparam int          CH_W           = 3;
  // Control word field positions.
  localparam int          ADDR_HI        = 7;
  localparam int          ADDR_LO        = 5;
  localparam int          TYPE_HI_BIT    = 4;
  localparam int          TYPE_LO_BIT    = 3;
  localparam int          MASK_SEL_BIT   = 2;
  localparam int          SEQ_BIT        = 1;
  // Reset values.
  localparam logic [11:0] CTRL_RST       = 12'h000;
  localparam logic [7:0]  MASK_RST       = 8'h00;
  localparam logic [2:0]  CH_RST         = 3'h0;
  // Conversion timing in whole conversion-clock periods.
  localparam int          CONV_PERIODS   = 13;
  // Half periods after which an abort leaves the sequencer unsafe.
  localparam int          ABORT_HALVES   = 25;
  // Even inputs only, used when pairs are converted.
  localparam logic [7:0]  PAIR_MASK      = 8'h55;
  localparam logic [2:0]  COMMON_NEG     = 3'h7;
  localparam logic [7:0]  NO_MASK        = 8'h00;

  // Input type, written as {input_type_high_bit, input_type_low_bit}.
  typedef enum logic [1:0] {
    IN_SINGLE   = 2'b00,
    IN_PSEUDO1  = 2'b01,
    IN_FULLDIFF = 2'b10,
    IN_PSEUDO2  = 2'b11
  } in_type_e;

  // Sequencer states.
  typedef enum logic [1:0] {
    SQ_IDLE   = 2'b00,
    SQ_ARMED  = 2'b01,
    SQ_MASKED = 2'b10,
    SQ_CONSEC = 2'b11
  } seq_state_e;
endpackage

// File: include/pin_evt_if.sv
// Purpose: Carries synchronised pin events from the pin stage to the sequencer.
// Assumes: All signals are on the core clock.
// Notes:   Events are one-cycle pulses.
`timescale 1ns/10ps
interface pin_evt_if;
  logic        wr_take;
  logic [11:0] wdata;
  logic        sample_start_n_fall;
  logic        sample_start_n_rise;
  logic        conversion_clock_input_edge;
  logic        conversion_clock_input_fall;
  modport src (output wr_take, wdata, sample_start_n_fall, sample_start_n_rise, conversion_clock_input_edge, conversion_clock_input_fall);
  modport dst (input  wr_take, wdata, sample_start_n_fall, sample_start_n_rise, conversion_clock_input_edge, conversion_clock_input_fall);
endinterface

// File: rtl/pin_event_sync.sv
// Purpose: Synchronises the bus and conversion pins and detects their edges.
// Assumes: The data lines are stable around the write strobe's rising edge.
// Notes:   Every pin passes two flip-flops before any logic looks at it.
`timescale 1ns/10ps
module pin_event_sync
  import adc_seq_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_cs_n,
  input  wire logic              i_wr_n,
  input  wire logic [CTRL_W-1:0] i_db,
  input  wire logic              i_sample_start_n,
  input  wire logic              i_conversion_clock_input,
  pin_evt_if.src                 evt
);
  // Bit order in the strobe vectors: cs_n, wr_n, sample_start_n, conversion clock.
  localparam logic [3:0] STRB_RST = 4'hE;

  logic [3:0]        strb_s1_r;
  logic [3:0]        strb_s2_r;
  logic [3:0]        strb_s3_r;
  logic [CTRL_W-1:0] db_s1_r;
  logic [CTRL_W-1:0] db_s2_r;

  // Two-stage synchronisers; the third stage only serves edge detection.
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strb_s1_r <= STRB_RST;
      strb_s2_r <= STRB_RST;
      strb_s3_r <= STRB_RST;
      db_s1_r   <= CTRL_RST;
      db_s2_r   <= CTRL_RST;
    end else begin
      strb_s1_r <= {i_cs_n, i_wr_n, i_sample_start_n, i_conversion_clock_input};
      strb_s2_r <= strb_s1_r;
      strb_s3_r <= strb_s2_r;
      db_s1_r   <= i_db;
      db_s2_r   <= db_s1_r;
    end
  end

  // A write is taken on the strobe's rising edge while chip select was low.
  assign evt.wr_take     = strb_s2_r[2] & ~strb_s3_r[2] & ~strb_s3_r[3];
  assign evt.wdata       = db_s2_r;
  assign evt.sample_start_n_fall = ~strb_s2_r[1] & strb_s3_r[1];
  assign evt.sample_start_n_rise = strb_s2_r[1] & ~strb_s3_r[1];
  assign evt.conversion_clock_input_edge  = strb_s2_r[0] ^ strb_s3_r[0];
  assign evt.conversion_clock_input_fall  = ~strb_s2_r[0] & strb_s3_r[0];
endmodule

// File: rtl/adc_channel_sequencer.sv
// Purpose: Control word, channel mask and channel sequencer of an eight-input converter.
// Assumes: Host writes over cs/wr strobes; pins are asynchronous to i_core_clk.
// Notes:   The selected input pair is presented at each sample start falling edge.
// How it works
// RULE1 - Conversion finishes only after thirteen whole conversion-clock periods, else it aborts.
// RULE2 - After a late abort host gives sample-start rise or clock fall before reprogramming.
// RULE3 - Single-ended: address n picks input n against analog ground.
// RULE4 - Fully differential: even address picks pair even-positive, odd address swaps it.
// RULE5 - First pseudo-differential mode maps pairs exactly like fully differential.
// RULE6 - Second pseudo-differential: input n against input 7; address 7 is forbidden.
// RULE7 - Sequencer off: each conversion uses the address of the latest control write.
// RULE8 - Mask-select alone set: next bus write loads low eight lines into mask.
// RULE9 - Sequence bit alone set: other fields change, running sequence continues.
// RULE10 - Both bits set: repeat channels 0 up to the written address.
// RULE11 - Mask register is eight bits, write-only, loaded at write strobe rise.
// RULE12 - Write goes to mask only right after a mask-select control write.
// RULE13 - Mask bit n means input n; host sets each wanted input.
// RULE14 - In pair modes host sets both bits of each wanted pair.
// RULE15 - Masked sequence converts selected channels ascending from lowest, cycling.
// RULE16 - Masked sequence advances one channel on each sample start falling edge.
// RULE17 - Any control write other than sequence-only ends the running sequence.
// RULE18 - Masked pair sequences convert only even-positive pairs, never reversed.
// RULE19 - Control register is twelve bits, write-only, written by cs and wr.
// RULE20 - Control register clears to zero at reset.
// RULE21 - Address field bits 7..5 gives next channel or final consecutive channel.
// RULE22 - Mask-select is bit 2, sequence bit is bit 1; they choose the mode.
// RULE23 - Consecutive mode wraps to channel 0 after the final channel.
`timescale 1ns/10ps
module adc_channel_sequencer
  import adc_seq_pkg::*;
#(
  parameter int N_CONV_PERIODS = CONV_PERIODS
)(
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_cs_n,
  input  wire logic              i_wr_n,
  input  wire logic [CTRL_W-1:0] i_db,
  input  wire logic              i_sample_start_n,
  input  wire logic              i_conversion_clock_input,
  output logic      [CTRL_W-1:0] o_ctrl_word,
  output logic      [CH_W-1:0]   o_vin_pos,
  output logic      [CH_W-1:0]   o_vin_neg,
  output logic                   o_neg_is_ground,
  output logic                   o_seq_active,
  output logic                   o_conv_busy,
  output logic                   o_conv_done,
  output logic                   o_conv_abort,
  output logic                   o_reprog_unsafe
);
  localparam int HALF_W    = $clog2(2 * N_CONV_PERIODS + 1);
  localparam int HALF_LAST = 2 * N_CONV_PERIODS - 1;

  // The abort threshold must sit inside a conversion, so shorter counts are refused.
  if (N_CONV_PERIODS < 1 || ABORT_HALVES > HALF_LAST) begin : g_bad_periods
    $error("N_CONV_PERIODS is too small for this sequencer");
  end

  // Release of the asynchronous reset through two flip-flops.
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  pin_evt_if evt ();

  pin_event_sync u_pins (
    .i_core_clk               (i_core_clk),
    .i_rst_n                  (rst_n),
    .i_cs_n                   (i_cs_n),
    .i_wr_n                   (i_wr_n),
    .i_db                     (i_db),
    .i_sample_start_n         (i_sample_start_n),
    .i_conversion_clock_input (i_conversion_clock_input),
    .evt                      (evt)
  );

  // First selected channel at or above 'from', wrapping; bit 3 flags a hit.
  function automatic logic [3:0] next_sel(input logic [7:0] mask, input logic [2:0] from);
    logic [2:0] idx;
    logic [3:0] res;
    res = 4'h0;
    for (int i = MASK_W - 1; i >= 0; i--) begin
      idx = from + 3'(i);
      if (mask[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  seq_state_e        state_r, state_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [MASK_W-1:0] mask_r, mask_nxt;
  logic [CH_W-1:0]   ptr_r, ptr_nxt;
  logic [CH_W-1:0]   last_r, last_nxt;
  logic [CH_W-1:0]   pos_r, pos_nxt;
  logic [CH_W-1:0]   neg_r, neg_nxt;
  logic              gnd_r, gnd_nxt;
  logic [HALF_W-1:0] half_r, half_nxt;
  logic              busy_r, busy_nxt;
  logic              done_r, done_nxt;
  logic              abort_r, abort_nxt;
  logic              unsafe_r, unsafe_nxt;

  in_type_e          in_type;
  logic [CH_W-1:0]   addr;
  logic [1:0]        wr_mode;
  logic [MASK_W-1:0] eff_mask;
  logic [3:0]        sel;
  logic [CH_W-1:0]   conv_ch;

  // Field decode of the current control word; the write mode comes from the incoming bus data.
  assign in_type  = in_type_e'({ctrl_r[TYPE_HI_BIT], ctrl_r[TYPE_LO_BIT]});
  assign addr     = ctrl_r[ADDR_HI:ADDR_LO]; // RULE21
  assign wr_mode  = {evt.wdata[SEQ_BIT], evt.wdata[MASK_SEL_BIT]}; // RULE22
  // Pair modes drop odd bits so masked selections never pick a reversed pair.
  assign eff_mask = (in_type == IN_FULLDIFF || in_type == IN_PSEUDO1) ?
                    (mask_r & PAIR_MASK) : mask_r; // RULE18 RULE13
  assign sel      = next_sel(eff_mask, ptr_r); // RULE15

  // Channel converted at this sample start edge; an empty mask falls back to the address.
  always_comb begin
    conv_ch = addr; // RULE7
    if (state_r == SQ_MASKED && sel[3]) begin
      conv_ch = sel[2:0];
    end else if (state_r == SQ_CONSEC) begin
      conv_ch = ptr_r;
    end
  end

  // Next state of the control, mask and sequencer registers.
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt  = ctrl_r;
    mask_nxt  = mask_r;
    ptr_nxt   = ptr_r;
    last_nxt  = last_r;
    pos_nxt   = pos_r;
    neg_nxt   = neg_r;
    gnd_nxt   = gnd_r;
    if (evt.sample_start_n_fall) begin
      pos_nxt = conv_ch;
      gnd_nxt = 1'b0;
      unique case (in_type)
        IN_SINGLE: begin
          neg_nxt = CH_RST;
          gnd_nxt = 1'b1; // RULE3
        end
        IN_FULLDIFF, IN_PSEUDO1: begin
          neg_nxt = conv_ch ^ 3'h1; // RULE4 RULE5
        end
        IN_PSEUDO2: begin
          neg_nxt = COMMON_NEG; // RULE6
        end
      endcase
      unique case (state_r)
        SQ_MASKED: begin
          if (sel[3]) begin
            ptr_nxt = sel[2:0] + 3'h1; // RULE16
          end
        end
        SQ_CONSEC: begin
          ptr_nxt = (ptr_r == last_r) ? CH_RST : ptr_r + 3'h1; // RULE10 RULE23
        end
        SQ_IDLE, SQ_ARMED: begin
          ptr_nxt = ptr_r;
        end
      endcase
    end
    // A write that lands with a sample start edge takes precedence over the advance.
    if (evt.wr_take) begin
      if (state_r == SQ_ARMED) begin
        mask_nxt  = evt.wdata[MASK_W-1:0]; // RULE8 RULE11 RULE12
        state_nxt = SQ_MASKED;
        ptr_nxt   = CH_RST;
      end else begin
        ctrl_nxt = evt.wdata; // RULE19
        unique case (wr_mode)
          2'b00: state_nxt = SQ_IDLE; // RULE17
          2'b01: state_nxt = SQ_ARMED; // RULE17
          2'b10: state_nxt = state_r; // RULE9
          2'b11: begin
            state_nxt = SQ_CONSEC; // RULE17
            last_nxt  = evt.wdata[ADDR_HI:ADDR_LO];
            ptr_nxt   = CH_RST;
          end
        endcase
      end
    end
  end

  // Sequencer and control registers.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SQ_IDLE;
      ctrl_r  <= CTRL_RST; // RULE20
      mask_r  <= MASK_RST;
      ptr_r   <= CH_RST;
      last_r  <= CH_RST;
      pos_r   <= CH_RST;
      neg_r   <= CH_RST;
      gnd_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
      mask_r  <= mask_nxt;
      ptr_r   <= ptr_nxt;
      last_r  <= last_nxt;
      pos_r   <= pos_nxt;
      neg_r   <= neg_nxt;
      gnd_r   <= gnd_nxt;
    end
  end

  // Conversion timing: every conversion-clock edge is a half period.
  always_comb begin
    half_nxt   = half_r;
    busy_nxt   = busy_r;
    done_nxt   = 1'b0;
    abort_nxt  = 1'b0;
    unsafe_nxt = unsafe_r;
    if (evt.sample_start_n_rise || evt.conversion_clock_input_fall) begin
      unsafe_nxt = 1'b0; // RULE2
    end
    if (evt.sample_start_n_fall) begin
      // A new start before the last period ends abandons the running conversion.
      if (busy_r) begin
        abort_nxt = 1'b1; // RULE1
        if (half_r >= HALF_W'(ABORT_HALVES)) begin
          unsafe_nxt = 1'b1; // RULE2
        end
      end
      busy_nxt = 1'b1;
      half_nxt = '0;
    end else if (busy_r && evt.conversion_clock_input_edge) begin
      if (half_r == HALF_W'(HALF_LAST)) begin
        done_nxt = 1'b1; // RULE1
        busy_nxt = 1'b0;
        half_nxt = '0;
      end else begin
        half_nxt = half_r + 1'b1;
      end
    end
  end

  // Conversion timing registers.
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_r   <= '0;
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      abort_r  <= 1'b0;
      unsafe_r <= 1'b0;
    end else begin
      half_r   <= half_nxt;
      busy_r   <= busy_nxt;
      done_r   <= done_nxt;
      abort_r  <= abort_nxt;
      unsafe_r <= unsafe_nxt;
    end
  end

  assign o_ctrl_word     = ctrl_r;
  assign o_vin_pos       = pos_r;
  assign o_vin_neg       = neg_r;
  assign o_neg_is_ground = gnd_r;
  assign o_seq_active    = state_r[1];
  assign o_conv_busy     = busy_r;
  assign o_conv_done     = done_r;
  assign o_conv_abort    = abort_r;
  assign o_reprog_unsafe = unsafe_r;

  // Checks on the sequencer behaviour.
  localparam int HALF_LAST_I = 2 * N_CONV_PERIODS - 1;

  sequence s_end_write;
    evt.wr_take && state_r != SQ_ARMED && wr_mode != 2'b10;
  endsequence

  sequence s_masked_step;
    evt.sample_start_n_fall && !evt.wr_take && state_r == SQ_MASKED && sel[3];
  endsequence

  a_conv_done_count: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE1
    o_conv_done |-> $past(half_r) == HALF_LAST_I && $past(busy_r) && !o_conv_busy)
    else $error("Conversion finished without its full clock count.");
  a_mask_load: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE12
    evt.wr_take && state_r == SQ_ARMED |=> mask_r == $past(evt.wdata[7:0]) && ctrl_r == $past(ctrl_r))
    else $error("Mask write did not load the mask alone.");
  a_ctrl_write: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE19
    evt.wr_take && state_r != SQ_ARMED |=> o_ctrl_word == $past(evt.wdata))
    else $error("Control write was not stored.");
  a_single_ground: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE3
    evt.sample_start_n_fall && in_type == IN_SINGLE |=> o_neg_is_ground && o_vin_pos == $past(conv_ch))
    else $error("Single-ended select is wrong.");
  a_pair_polarity: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE4
    evt.sample_start_n_fall && in_type inside {IN_FULLDIFF, IN_PSEUDO1}
    |=> !o_neg_is_ground && o_vin_neg == (o_vin_pos ^ 3'h1))
    else $error("Differential pair is wrong.");
  a_common_neg: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE6
    evt.sample_start_n_fall && in_type == IN_PSEUDO2 |=> o_vin_neg == COMMON_NEG && !o_neg_is_ground)
    else $error("Common negative input is wrong.");
  a_idle_addr: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE7
    evt.sample_start_n_fall && state_r == SQ_IDLE |=> o_vin_pos == $past(addr))
    else $error("Idle conversion ignored the address field.");
  a_consec_wrap: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE23
    evt.sample_start_n_fall && !evt.wr_take && state_r == SQ_CONSEC && ptr_r == last_r |=> ptr_r == 3'h0)
    else $error("Consecutive sequence did not wrap.");
  a_masked_step: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE16
    s_masked_step |=> ptr_r == $past(sel[2:0]) + 3'h1 && mask_r[o_vin_pos])
    else $error("Masked sequence did not step to a selected channel.");
  a_even_only: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE18
    s_masked_step ##0 (in_type inside {IN_FULLDIFF, IN_PSEUDO1}) |=> !o_vin_pos[0])
    else $error("Masked pair sequence used a reversed pair.");
  a_seq_end: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE17
    s_end_write ##0 (wr_mode != 2'b11) |=> !o_seq_active)
    else $error("Sequence kept running after an ending write.");
  a_seq_keep: assert property (@(posedge i_core_clk) disable iff (!rst_n) // RULE9
    evt.wr_take && state_r != SQ_ARMED && wr_mode == 2'b10 |=> $stable(state_r))
    else $error("Sequence-only write changed the sequencer state.");
endmodule

// File: verif/adc_host_model.sv
// Purpose: Host processor model driving the bus, sample start and conversion clock pins.
// Assumes: Every pin changes at a falling edge of the core clock.
// Notes:   Levels are held at least four core clocks so the pin stage sees each one.
`timescale 1ns/10ps
module adc_host_model
  import adc_seq_pkg::*;
(
  input  wire logic              i_core_clk,
  output logic                   o_cs_n,
  output logic                   o_wr_n,
  output logic      [CTRL_W-1:0] o_db,
  output logic                   o_sample_start_n,
  output logic                   o_conversion_clock_input
);
  // Idle levels; the clock stands still outside clock_edges calls.
  initial begin
    o_cs_n                   = 1'b1;
    o_wr_n                   = 1'b1;
    o_db                     = 12'hAAA;
    o_sample_start_n         = 1'b1;
    o_conversion_clock_input = 1'b0;
  end

  // One bus write; data is held past the strobe rise, then inverted because it is undriven.
  task automatic bus_write(input logic [CTRL_W-1:0] data);
    @(negedge i_core_clk);
    o_cs_n = 1'b0;
    o_db   = data;
    o_wr_n = 1'b0;
    repeat (4) @(negedge i_core_clk);
    o_wr_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    o_cs_n = 1'b1;
    o_db   = ~data;
    repeat (4) @(negedge i_core_clk);
  endtask

  // A write strobe with chip select held high; the device must ignore it.
  task automatic stray_write(input logic [CTRL_W-1:0] data);
    @(negedge i_core_clk);
    o_db   = data;
    o_wr_n = 1'b0;
    repeat (4) @(negedge i_core_clk);
    o_wr_n = 1'b1;
    repeat (4) @(negedge i_core_clk);
    o_db   = ~data;
    repeat (4) @(negedge i_core_clk);
  endtask

  // Sets the sample start level and lets the pin stage settle.
  task automatic start_level(input logic lvl);
    @(negedge i_core_clk);
    o_sample_start_n = lvl;
    repeat (5) @(negedge i_core_clk);
  endtask

  // A full pulse ends on a rising edge, so reprogramming after it is always safe.
  task automatic start_pulse();
    start_level(1'b0);
    start_level(1'b1);
  endtask

  // Applies a number of conversion clock edges, four core clocks per level.
  task automatic clock_edges(input int num);
    repeat (num) begin
      repeat (4) @(negedge i_core_clk);
      o_conversion_clock_input = ~o_conversion_clock_input;
    end
    repeat (4) @(negedge i_core_clk);
  endtask
endmodule

// File: verif/test_adc_channel_sequencer.sv
// Purpose: Self-checking bench for the channel sequencer.
// Assumes: The host model drives all bus and conversion pins.
// Notes:   Selection rows run in a loop; sequences and aborts are hand-written.
`timescale 1ns/10ps
module test_adc_channel_sequencer
  import adc_seq_pkg::*;
;

  typedef struct packed {
    logic [11:0] ctrl;
    logic [2:0]  pos;
    logic [2:0]  neg;
    logic        gnd;
  } sel_row_s;

  logic              clk;
  logic              nrst;
  logic              cs_n;
  logic              wr_n;
  logic [CTRL_W-1:0] db;
  logic              ssn;
  logic              cclk;
  logic [CTRL_W-1:0] ctrl_word;
  logic [CH_W-1:0]   vin_pos;
  logic [CH_W-1:0]   vin_neg;
  logic              neg_gnd;
  logic              seq_active;
  logic              busy;
  logic              done;
  logic              abort;
  logic              unsafe;
  int                fails;
  int                checked;
  int                done_cnt;
  int                abort_cnt;
  int                d0;
  int                a0;
  sel_row_s          rows [8];

  adc_host_model adc_host_model_i (
    .i_core_clk               (clk),
    .o_cs_n                   (cs_n),
    .o_wr_n                   (wr_n),
    .o_db                     (db),
    .o_sample_start_n         (ssn),
    .o_conversion_clock_input (cclk)
  );

  adc_channel_sequencer #(.N_CONV_PERIODS(CONV_PERIODS)) adc_channel_sequencer_i (
    .i_core_clk               (clk),
    .i_nrst                   (nrst),
    .i_cs_n                   (cs_n),
    .i_wr_n                   (wr_n),
    .i_db                     (db),
    .i_sample_start_n         (ssn),
    .i_conversion_clock_input (cclk),
    .o_ctrl_word              (ctrl_word),
    .o_vin_pos                (vin_pos),
    .o_vin_neg                (vin_neg),
    .o_neg_is_ground          (neg_gnd),
    .o_seq_active             (seq_active),
    .o_conv_busy              (busy),
    .o_conv_done              (done),
    .o_conv_abort             (abort),
    .o_reprog_unsafe          (unsafe)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Done and abort are single-cycle pulses, so they are counted at the settled edge.
  always @(negedge clk) begin
    if (done === 1'b1) done_cnt++;
    if (abort === 1'b1) abort_cnt++;
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_sel(input logic [2:0] p, input logic [2:0] n, input logic g);
    check(12'(vin_pos), 12'(p));
    check(12'(vin_neg), 12'(n));
    check(12'(neg_gnd), 12'(g));
  endtask

  // One conversion start, then the selection it presented.
  task automatic step(input logic [2:0] p, input logic [2:0] n, input logic g);
    adc_host_model_i.start_pulse();
    chk_sel(p, n, g);
  endtask

  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly one thousand cycles the tests take.
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    test_done();
  end

  initial begin
    nrst      = 1'b0;
    fails     = 0;
    checked   = 0;
    done_cnt  = 0;
    abort_cnt = 0;
    // Control word, expected positive, negative and ground flag.
    rows = '{'{12'hCA1, 3'h5, 3'h0, 1'b1}, '{12'h0E0, 3'h7, 3'h0, 1'b1},
             '{12'h050, 3'h2, 3'h3, 1'b0}, '{12'h070, 3'h3, 3'h2, 1'b0},
             '{12'h0C8, 3'h6, 3'h7, 1'b0}, '{12'h028, 3'h1, 3'h0, 1'b0},
             '{12'h098, 3'h4, 3'h7, 1'b0}, '{12'h018, 3'h0, 3'h7, 1'b0}};
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    check(ctrl_word, 12'h000);
    chk_sel(3'h0, 3'h0, 1'b1);
    check(12'(seq_active), 12'h000);
    // Sequencer off: every write picks the channel directly.
    foreach (rows[i]) begin
      adc_host_model_i.bus_write(rows[i].ctrl);
      check(ctrl_word, rows[i].ctrl);
      step(rows[i].pos, rows[i].neg, rows[i].gnd);
    end
    // Masked single-ended sequence over inputs 1, 4 and 7; upper data bits ignored.
    adc_host_model_i.bus_write(12'h004);
    adc_host_model_i.bus_write(12'hF92);
    check(ctrl_word, 12'h004);
    step(3'h1, 3'h0, 1'b1);
    check(12'(seq_active), 12'h001);
    step(3'h4, 3'h0, 1'b1);
    step(3'h7, 3'h0, 1'b1);
    adc_host_model_i.bus_write(12'h102);
    check(ctrl_word, 12'h102);
    step(3'h1, 3'h0, 1'b1);
    step(3'h4, 3'h0, 1'b1);
    adc_host_model_i.bus_write(12'h060);
    check(12'(seq_active), 12'h000);
    step(3'h3, 3'h0, 1'b1);
    // Masked fully differential pairs 2-3 and 4-5; reversed pairs never appear.
    adc_host_model_i.bus_write(12'h014);
    adc_host_model_i.bus_write(12'h03C);
    step(3'h2, 3'h3, 1'b0);
    step(3'h4, 3'h5, 1'b0);
    step(3'h2, 3'h3, 1'b0);
    // Consecutive sequence up to channel 2, then wrap.
    adc_host_model_i.bus_write(12'h046);
    check(12'(seq_active), 12'h001);
    step(3'h0, 3'h0, 1'b1);
    step(3'h1, 3'h0, 1'b1);
    step(3'h2, 3'h0, 1'b1);
    step(3'h0, 3'h0, 1'b1);
    adc_host_model_i.bus_write(12'h000);
    // Abort after 12.5 periods leaves reprogramming unsafe until a start rise.
    adc_host_model_i.start_pulse();
    d0 = done_cnt;
    a0 = abort_cnt;
    adc_host_model_i.clock_edges(25);
    adc_host_model_i.start_level(1'b0);
    check(12'(abort_cnt - a0), 12'h001);
    check(12'(unsafe), 12'h001);
    adc_host_model_i.start_level(1'b1);
    check(12'(unsafe), 12'h000);
    // Abort after only 12 periods is not unsafe.
    adc_host_model_i.clock_edges(24);
    adc_host_model_i.start_level(1'b0);
    check(12'(abort_cnt - a0), 12'h002);
    check(12'(unsafe), 12'h000);
    adc_host_model_i.start_level(1'b1);
    // Exactly thirteen periods complete the conversion.
    adc_host_model_i.clock_edges(25);
    check(12'(done_cnt - d0), 12'h000);
    check(12'(busy), 12'h001);
    adc_host_model_i.clock_edges(1);
    check(12'(done_cnt - d0), 12'h001);
    check(12'(busy), 12'h000);
    // A strobe without chip select must leave the control word alone.
    adc_host_model_i.stray_write(12'h046);
    check(ctrl_word, 12'h000);
    check(12'(seq_active), 12'h000);
    // Reset in mid-run clears a running consecutive sequence.
    adc_host_model_i.bus_write(12'h046);
    check(12'(seq_active), 12'h001);
    @(negedge clk);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    check(ctrl_word, 12'h000);
    check(12'(seq_active), 12'h000);
    nrst = 1'b1;
    repeat (5) @(negedge clk);
    chk_sel(3'h0, 3'h0, 1'b1);
    // Clock edges with no conversion running are ignored.
    d0 = done_cnt;
    adc_host_model_i.clock_edges(26);
    check(12'(done_cnt - d0), 12'h000);
    check(12'(busy), 12'h000);
    step(3'h0, 3'h0, 1'b1);
    test_done();
  end
endmodule
